// ### rtl/dsso_pkg.sv
package dsso_pkg;

  // Parameter indices on the parameter access port
  localparam logic [7:0] IDX_DRIVE_MODEL    = 8'h00;
  localparam logic [7:0] IDX_RATED_ARM      = 8'h01;
  localparam logic [7:0] IDX_RATED_FLD      = 8'h02;
  localparam logic [7:0] IDX_FW_VERSION     = 8'h03;
  localparam logic [7:0] IDX_CTL_ID_RAW     = 8'h04;
  localparam logic [7:0] IDX_CTL_ID         = 8'h05;
  localparam logic [7:0] IDX_MODEL_CAT      = 8'h06;
  localparam logic [7:0] IDX_EDIT_ACTIVE    = 8'h07;
  localparam logic [7:0] IDX_RESET_CAUSE    = 8'h08;
  localparam logic [7:0] IDX_PHASE_MISSING  = 8'h09;
  localparam logic [7:0] IDX_CT_ID          = 8'h0a;
  localparam logic [7:0] IDX_HS_CODE        = 8'h0b;
  localparam logic [7:0] IDX_HS_CELSIUS     = 8'h0c;
  localparam logic [7:0] IDX_HS_OT_LEVEL    = 8'h0d;
  localparam logic [7:0] IDX_NVM_FAULT      = 8'h0e;
  localparam logic [7:0] IDX_NVM_ALARM      = 8'h0f;
  localparam logic [7:0] IDX_OPT_ID_RAW     = 8'h10;
  localparam logic [7:0] IDX_OPT_ID         = 8'h11;
  localparam logic [7:0] IDX_SAVE_ALL       = 8'h12;
  localparam logic [7:0] IDX_LINE_SEL       = 8'h13;
  localparam logic [7:0] IDX_LINE_STATUS    = 8'h14;
  localparam logic [7:0] IDX_REGEN_EN       = 8'h15;
  localparam logic [7:0] IDX_FAN_MODE       = 8'h16;
  localparam logic [7:0] IDX_FAN_STATUS     = 8'h17;

  // Field encodings
  localparam logic [15:0] VAL_OFF           = 16'h0000;
  localparam logic [15:0] VAL_ON            = 16'h0001;
  localparam logic [1:0]  LSEL_AUTO         = 2'h0;
  localparam logic [1:0]  LSEL_50           = 2'h1;
  localparam logic [1:0]  LSEL_60           = 2'h2;
  localparam logic [15:0] HZ_50             = 16'h0032;
  localparam logic [15:0] HZ_60             = 16'h003c;
  localparam logic [1:0]  RST_EXTERNAL      = 2'h0;
  localparam logic [1:0]  RST_WATCHDOG      = 2'h1;
  localparam logic [1:0]  RST_SOFTWARE      = 2'h2;
  localparam logic [1:0]  NVM_NO_FAULT      = 2'h0;
  localparam logic [1:0]  NVM_READ_FAULT    = 2'h1;
  localparam logic [1:0]  NVM_WRITE_FAULT   = 2'h2;

  // Values after reset
  localparam logic [1:0]  RST_LINE_SEL      = LSEL_AUTO;
  localparam logic        RST_REGEN_EN      = 1'b1;
  localparam logic        RST_FAN_FORCED    = 1'b0;

  // Line period measurement in 10 us ticks
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          TICK_NS           = 10000;
  localparam int          TICK_CYC          = TICK_NS / CLK_PERIOD_NS;
  localparam logic [11:0] PER_MIN_TICKS     = 12'h5dc;  // 15 ms
  localparam logic [11:0] PER_SPLIT_TICKS   = 12'h729;  // 18.33 ms
  localparam logic [11:0] PER_MAX_TICKS     = 12'h898;  // 22 ms

  typedef enum logic [1:0] {
    NVM_IDLE = 2'b00,
    NVM_ISSUE = 2'b01,
    NVM_WAIT = 2'b10
  } dsso_nvm_state_t;

endpackage : dsso_pkg

// ### rtl/dsso_system_status.sv
// Summary of operation
// - Flag keypad edit in progress; block run while it is set.
// - Record last reset cause: external, watchdog or software.
// - Phase-missing flag set while any of three supply phases absent.
// - Over-temperature fault when heatsink Celsius exceeds threshold level.
// - Expose raw heatsink converter code and scaled Celsius, read-only.
// - Report outcome of each memory operation: none, read or write fault.
// - Raise memory alarm on failed store; latch code of failing attempt.
// - Keypad parameter changes are committed to memory automatically.
// - Port parameter changes update working values only, no memory store.
// - Writing on to save request stores SAVE_COUNT slots from its own index, not fan mode; control returns off itself.
// - Line frequency selector: auto measures, or forces 50 or 60 Hz.
// - Line status shows measured frequency in auto, else selected one.
// - Regen disable turns off reverse bridge on regen models only.
// - Fan auto mode follows heatsink temperature; forced mode keeps on.
// - Fan status shows whether the fans are running.
// - Model category reads regenerative or non-regenerative.
// - Board identifiers readable, raw and decoded where both exist.
// - Line selector and regen enable refuse changes while running.
`timescale 1ns/10ps
`default_nettype none

module dsso_system_status
  import dsso_pkg::*;
#(
  parameter int               SAVE_COUNT   = 4,
  parameter logic [15:0]      OT_LEVEL_C   = 16'h005a,
  parameter logic [15:0]      FAN_ON_C     = 16'h0032,
  parameter logic [15:0]      FAN_OFF_C    = 16'h002d,
  parameter logic [15:0]      HS_MUL       = 16'h0064,
  parameter int               HS_SHIFT     = 10,
  parameter logic [15:0]      HS_OFFS_C    = 16'h0000,
  parameter logic [15:0]      DRIVE_MODEL  = 16'h0001,  // Arbitrary value
  parameter logic [15:0]      RATED_ARM    = 16'h0014,
  parameter logic [15:0]      RATED_FLD    = 16'h0002,
  parameter logic [15:0]      FW_VERSION   = 16'h0100   // Arbitrary value
)(
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire logic           prm_req,
  input  wire logic           prm_wr,
  input  wire logic           prm_from_keypad,
  input  wire logic [7:0]     prm_addr,
  input  wire logic [15:0]    prm_wdata,
  output logic                prm_ack,
  output logic [15:0]         prm_rdata,
  input  wire logic           keypad_editing,
  input  wire logic           run_request,
  output logic                run_permit,
  input  wire logic           drive_running,
  input  wire logic           rst_by_watchdog,
  input  wire logic           rst_by_software,
  input  wire logic           regen_model,
  input  wire logic [2:0]     phase_absent,
  input  wire logic           line_zero_cross,
  input  wire logic           hs_code_valid,
  input  wire logic [15:0]    hs_code,
  input  wire logic [15:0]    ctl_board_id_raw,
  input  wire logic [15:0]    ct_board_id,
  input  wire logic [15:0]    opt_board_id_raw,
  output logic                nvm_wr_req,
  output logic [7:0]          nvm_wr_addr,
  output logic [15:0]         nvm_wr_data,
  input  wire logic           nvm_busy,
  input  wire logic           nvm_op_done,
  input  wire logic           nvm_op_read,
  input  wire logic           nvm_op_err,
  output logic                nvm_alarm,
  output logic                over_temperature,
  output logic                reverse_bridge_en,
  output logic                fan_on
);

  initial begin
    if (SAVE_COUNT < 1 || SAVE_COUNT > 256)
      $error("SAVE_COUNT out of range");
    if (HS_SHIFT < 0 || HS_SHIFT > 16)
      $error("HS_SHIFT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for pins

  logic [4:0]                 pin_s1_r;
  logic [4:0]                 pin_s2_r;
  logic                       zc_prev_r;

  always_ff @(posedge clk)
  begin
    pin_s1_r  <= {line_zero_cross, keypad_editing, phase_absent};
    pin_s2_r  <= pin_s1_r;
    zc_prev_r <= pin_s2_r[4];
  end

  wire        edit_active   = pin_s2_r[3];
  wire        phase_missing = |pin_s2_r[2:0];
  wire        zc_rise       = pin_s2_r[4] & ~zc_prev_r;

  assign run_permit = run_request & ~edit_active;

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause and model strap, caught on the first cycle after release

  logic                       strap_done_r;
  logic [1:0]                 rst_cause_r;
  logic                       regen_model_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      strap_done_r  <= 1'b0;
      rst_cause_r   <= RST_EXTERNAL;
      regen_model_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r  <= 1'b1;
      regen_model_r <= regen_model;
      if (rst_by_watchdog)
        rst_cause_r <= RST_WATCHDOG;
      else if (rst_by_software)
        rst_cause_r <= RST_SOFTWARE;
      else
        rst_cause_r <= RST_EXTERNAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Heatsink temperature and fan control

  logic [15:0]                hs_code_r;
  logic [15:0]                hs_c_r;
  logic                       fan_auto_on_r;
  logic                       fan_forced_r;

  wire [31:0] hs_prod   = 32'(hs_code) * 32'(HS_MUL);
  wire [31:0] hs_shift  = hs_prod >> HS_SHIFT;
  wire [15:0] hs_scaled = (hs_shift[31:16] != 16'h0000) ? 16'hffff : hs_shift[15:0];
  wire [15:0] hs_c_nxt  = (hs_scaled > HS_OFFS_C) ? hs_scaled - HS_OFFS_C : 16'h0000;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hs_code_r     <= 16'h0000;
      hs_c_r        <= 16'h0000;
      fan_auto_on_r <= 1'b0;
    end
    else
    begin
      if (hs_code_valid)
      begin
        hs_code_r <= hs_code;
        hs_c_r    <= hs_c_nxt;
      end
      // Hysteresis keeps the fans from chattering at one threshold
      if (hs_c_r >= FAN_ON_C)
        fan_auto_on_r <= 1'b1;
      else if (hs_c_r <= FAN_OFF_C)
        fan_auto_on_r <= 1'b0;
    end
  end

  assign over_temperature = hs_c_r > OT_LEVEL_C;
  assign fan_on           = fan_forced_r | fan_auto_on_r;

  ////////////////////////////////////////////////////////////////////////////
  // Line frequency measurement

  logic [15:0]                tick_cnt_r;
  logic [11:0]                per_cnt_r;
  logic [15:0]                meas_hz_r;

  wire tick      = (tick_cnt_r == 16'(TICK_CYC - 1));
  wire per_full  = (per_cnt_r == PER_MAX_TICKS);
  wire per_valid = (per_cnt_r >= PER_MIN_TICKS);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tick_cnt_r <= 16'h0000;
      per_cnt_r  <= 12'h000;
      meas_hz_r  <= 16'h0000;
    end
    else
    begin
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      if (zc_rise)
      begin
        per_cnt_r <= 12'h000;
        if (per_valid && !per_full)
          meas_hz_r <= (per_cnt_r >= PER_SPLIT_TICKS) ? HZ_50 : HZ_60;
        else
          meas_hz_r <= 16'h0000;
      end
      else if (tick && !per_full)
        per_cnt_r <= per_cnt_r + 12'h001;
      else if (per_full)
        meas_hz_r <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable options and write decode

  logic [1:0]                 line_sel_r;
  logic                       regen_en_r;
  logic                       save_busy_r;

  wire wr_acc     = prm_req & prm_wr;
  wire wr_line    = wr_acc & (prm_addr == IDX_LINE_SEL);
  wire wr_regen   = wr_acc & (prm_addr == IDX_REGEN_EN);
  wire wr_fan     = wr_acc & (prm_addr == IDX_FAN_MODE);
  wire wr_save    = wr_acc & (prm_addr == IDX_SAVE_ALL);
  wire line_legal = (prm_wdata == 16'(LSEL_AUTO)) | (prm_wdata == 16'(LSEL_50))
                  | (prm_wdata == 16'(LSEL_60));
  wire bit_legal  = (prm_wdata[15:1] == 15'h0000);
  // Change-inhibited fields stay put during run
  wire line_take  = wr_line & line_legal & ~drive_running;
  wire regen_take = wr_regen & bit_legal & ~drive_running;
  wire fan_take   = wr_fan & bit_legal;
  wire save_take  = wr_save & (prm_wdata == VAL_ON) & ~save_busy_r;
  wire opt_take   = line_take | regen_take | fan_take;
  // Other addresses hold read-only or no state, so a write is dropped

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      line_sel_r   <= RST_LINE_SEL;
      regen_en_r   <= RST_REGEN_EN;
      fan_forced_r <= RST_FAN_FORCED;
    end
    else
    begin
      if (line_take)
        line_sel_r <= prm_wdata[1:0];
      if (regen_take)
        regen_en_r <= prm_wdata[0];
      if (fan_take)
        fan_forced_r <= prm_wdata[0];
    end
  end

  assign reverse_bridge_en = regen_model_r & regen_en_r;

  wire [15:0] line_status = (line_sel_r == LSEL_50) ? HZ_50 :
                            (line_sel_r == LSEL_60) ? HZ_60 : meas_hz_r;

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile store sequencer

  dsso_nvm_state_t            nvm_st_r;
  logic                       kp_pend_r;
  logic [7:0]                 kp_idx_r;
  logic [7:0]                 save_idx_r;
  logic                       cur_is_save_r;
  logic [7:0]                 cur_idx_r;
  logic [1:0]                 nvm_fault_r;
  logic                       alarm_r;
  logic [15:0]                alarm_code_r;
  logic                       save_err_r;
  logic                       nvm_req_r;
  logic [7:0]                 nvm_addr_r;
  logic [15:0]                nvm_data_r;

  // Keypad-only auto commit; port option writes never queue a store
  wire kp_store  = opt_take & prm_from_keypad;
  wire start_kp  = (nvm_st_r == NVM_IDLE) & kp_pend_r & ~save_busy_r;
  wire start_sv  = (nvm_st_r == NVM_IDLE) & save_busy_r;
  wire wr_done   = (nvm_st_r == NVM_WAIT) & nvm_op_done & ~nvm_op_read;
  wire last_save = (save_idx_r == 8'(SAVE_COUNT - 1));

  function automatic logic [15:0] opt_value(input logic [7:0] idx);
    case (idx)
      IDX_LINE_SEL: opt_value = 16'(line_sel_r);
      IDX_REGEN_EN: opt_value = 16'(regen_en_r);
      IDX_FAN_MODE: opt_value = 16'(fan_forced_r);
      default:      opt_value = 16'h0000;
    endcase
  endfunction

  // Save-all walks SAVE_COUNT slots in order starting at its own base
  wire [7:0] save_addr = IDX_SAVE_ALL + save_idx_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nvm_st_r      <= NVM_IDLE;
      kp_pend_r     <= 1'b0;
      kp_idx_r      <= 8'h00;
      save_busy_r   <= 1'b0;
      save_idx_r    <= 8'h00;
      save_err_r    <= 1'b0;
      cur_is_save_r <= 1'b0;
      cur_idx_r     <= 8'h00;
      nvm_req_r     <= 1'b0;
      nvm_addr_r    <= 8'h00;
      nvm_data_r    <= 16'h0000;
    end
    else
    begin
      nvm_req_r <= 1'b0;
      if (kp_store)
      begin
        kp_pend_r <= 1'b1;
        kp_idx_r  <= prm_addr;
      end
      else if (start_kp)
        kp_pend_r <= 1'b0;
      if (save_take)
      begin
        save_busy_r <= 1'b1;
        save_idx_r  <= 8'h00;
        save_err_r  <= 1'b0;
      end
      case (nvm_st_r)
        NVM_IDLE:
        begin
          if (start_sv || start_kp)
          begin
            cur_is_save_r <= start_sv;
            cur_idx_r     <= start_sv ? save_addr : kp_idx_r;
            nvm_st_r      <= NVM_ISSUE;
          end
        end
        NVM_ISSUE:
        begin
          if (!nvm_busy)
          begin
            nvm_req_r  <= 1'b1;
            nvm_addr_r <= cur_idx_r;
            nvm_data_r <= opt_value(cur_idx_r);
            nvm_st_r   <= NVM_WAIT;
          end
        end
        NVM_WAIT:
        begin
          if (wr_done)
          begin
            nvm_st_r <= NVM_IDLE;
            if (cur_is_save_r)
            begin
              if (nvm_op_err)
                save_err_r <= 1'b1;
              if (last_save)
                save_busy_r <= 1'b0;
              else
                save_idx_r <= save_idx_r + 8'h01;
            end
          end
        end
        default:
          nvm_st_r <= NVM_IDLE;
      endcase
    end
  end

  assign nvm_wr_req  = nvm_req_r;
  assign nvm_wr_addr = nvm_addr_r;
  assign nvm_wr_data = nvm_data_r;

  // A clean full save clears the alarm, but a fresh failure wins
  wire alarm_set = wr_done & nvm_op_err;
  wire alarm_clr = wr_done & cur_is_save_r & last_save & ~save_err_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nvm_fault_r  <= NVM_NO_FAULT;
      alarm_r      <= 1'b0;
      alarm_code_r <= 16'h0000;
    end
    else
    begin
      if (nvm_op_done)
        nvm_fault_r <= !nvm_op_err ? NVM_NO_FAULT :
                       nvm_op_read ? NVM_READ_FAULT : NVM_WRITE_FAULT;
      if (alarm_set)
      begin
        alarm_r      <= 1'b1;
        alarm_code_r <= {7'h00, cur_is_save_r, cur_idx_r};
      end
      else if (alarm_clr)
        alarm_r <= 1'b0;
    end
  end

  assign nvm_alarm = alarm_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and access answer

  logic [15:0]                rd_mux;
  logic [15:0]                rdata_r;
  logic                       ack_r;

  always_comb
  begin
    case (prm_addr)
      IDX_DRIVE_MODEL:   rd_mux = DRIVE_MODEL;
      IDX_RATED_ARM:     rd_mux = RATED_ARM;
      IDX_RATED_FLD:     rd_mux = RATED_FLD;
      IDX_FW_VERSION:    rd_mux = FW_VERSION;
      IDX_CTL_ID_RAW:    rd_mux = ctl_board_id_raw;
      IDX_CTL_ID:        rd_mux = {8'h00, ctl_board_id_raw[7:0]};
      IDX_MODEL_CAT:     rd_mux = 16'(regen_model_r);
      IDX_EDIT_ACTIVE:   rd_mux = 16'(edit_active);
      IDX_RESET_CAUSE:   rd_mux = 16'(rst_cause_r);
      IDX_PHASE_MISSING: rd_mux = 16'(phase_missing);
      IDX_CT_ID:         rd_mux = ct_board_id;
      IDX_HS_CODE:       rd_mux = hs_code_r;
      IDX_HS_CELSIUS:    rd_mux = hs_c_r;
      IDX_HS_OT_LEVEL:   rd_mux = OT_LEVEL_C;
      IDX_NVM_FAULT:     rd_mux = 16'(nvm_fault_r);
      IDX_NVM_ALARM:     rd_mux = alarm_code_r;
      IDX_OPT_ID_RAW:    rd_mux = opt_board_id_raw;
      IDX_OPT_ID:        rd_mux = {8'h00, opt_board_id_raw[7:0]};
      IDX_SAVE_ALL:      rd_mux = 16'(save_busy_r);
      IDX_LINE_SEL:      rd_mux = 16'(line_sel_r);
      IDX_LINE_STATUS:   rd_mux = line_status;
      IDX_REGEN_EN:      rd_mux = 16'(regen_en_r);
      IDX_FAN_MODE:      rd_mux = 16'(fan_forced_r);
      IDX_FAN_STATUS:    rd_mux = 16'(fan_on);
      default:           rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata_r <= 16'h0000;
      ack_r   <= 1'b0;
    end
    else
    begin
      ack_r <= prm_req;
      if (prm_req && !prm_wr)
        rdata_r <= rd_mux;
    end
  end

  assign prm_ack   = ack_r;
  assign prm_rdata = rdata_r;

endmodule : dsso_system_status

`default_nettype wire

// ### tb/dsso_nvm_model.sv
`timescale 1ns/10ps
`default_nettype none

module dsso_nvm_model (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic nvm_wr_req,
  input  wire logic fail,
  input  wire logic slow,
  input  wire logic rd_kick,
  output logic      nvm_busy,
  output logic      nvm_op_done,
  output logic      nvm_op_read,
  output logic      nvm_op_err
);
  logic [3:0] cnt_r;
  logic       tog_r;
  logic       rd_r;

  // A kick while idle stands in for a read done elsewhere in the drive
  always_ff @(posedge clk)
  begin
    tog_r <= ~tog_r & ~srst;
    if (srst)
    begin
      cnt_r <= 4'h0;
      rd_r  <= 1'b0;
    end
    else if (nvm_wr_req)
    begin
      cnt_r <= slow ? 4'h6 : 4'h1;
      rd_r  <= 1'b0;
    end
    else if (rd_kick && cnt_r == 4'h0)
    begin
      cnt_r <= 4'h1;
      rd_r  <= 1'b1;
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end

  assign nvm_busy    = (cnt_r > 4'h1);
  assign nvm_op_done = (cnt_r == 4'h1);
  // Qualifiers are junk outside done, so stale values cannot pass
  assign nvm_op_err  = nvm_op_done ? fail : tog_r;
  assign nvm_op_read = nvm_op_done ? rd_r : ~tog_r;
endmodule // dsso_nvm_model

`default_nettype wire

// ### tb/dsso_system_status_sva.sv
`timescale 1ns/10ps
`default_nettype none

module dsso_system_status_sva
  import dsso_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        prm_req,
  input wire logic        prm_wr,
  input wire logic        prm_from_keypad,
  input wire logic [7:0]  prm_addr,
  input wire logic [15:0] prm_wdata,
  input wire logic        prm_ack,
  input wire logic        keypad_editing,
  input wire logic        run_request,
  input wire logic        run_permit,
  input wire logic        drive_running,
  input wire logic        nvm_wr_req,
  input wire logic [7:0]  nvm_wr_addr,
  input wire logic        nvm_op_done,
  input wire logic        nvm_op_read,
  input wire logic        nvm_op_err,
  input wire logic        nvm_alarm,
  input wire logic        reverse_bridge_en,
  input wire logic        fan_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ack_follows: assert property (prm_ack == $past(prm_req))
    else $error("ack does not follow request");
  a_permit_needs: assert property (run_permit |-> run_request)
    else $error("run permitted without request");
  a_edit_blocks: assert property (keypad_editing [*4] |-> !run_permit)
    else $error("run permitted during keypad edit");
  a_regen_off: assert property (prm_req && prm_wr && prm_addr == IDX_REGEN_EN
      && prm_wdata == VAL_OFF && !drive_running |=> !reverse_bridge_en)
    else $error("reverse bridge still enabled");
  a_regen_locked: assert property (prm_req && prm_wr && prm_addr == IDX_REGEN_EN
      && drive_running |=> $stable(reverse_bridge_en))
    else $error("regen enable changed while running");
  a_fan_forced: assert property (prm_req && prm_wr && prm_addr == IDX_FAN_MODE
      && prm_wdata == VAL_ON |=> fan_on)
    else $error("fans not on in forced mode");
  a_keypad_store: assert property (prm_req && prm_wr && prm_from_keypad
      && prm_addr == IDX_FAN_MODE |-> ##[2:40] nvm_wr_req && nvm_wr_addr == IDX_FAN_MODE)
    else $error("keypad change not stored");
  a_alarm_set: assert property (nvm_op_done && nvm_op_err && !nvm_op_read |=> nvm_alarm)
    else $error("failed store raised no alarm");
  a_alarm_clear: assert property ($fell(nvm_alarm) |-> $past(nvm_op_done)
      || $past(nvm_op_done, 2))
    else $error("alarm cleared without a finished store");
endmodule // dsso_system_status_sva

bind dsso_system_status dsso_system_status_sva i_dsso_system_status_sva (.*);

`default_nettype wire

// ### tb/dsso_system_status_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dsso_system_status_tb;
  import dsso_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, prm_req = 1'b0, prm_wr = 1'b0, prm_from_keypad = 1'b0;
  logic        keypad_editing = 1'b0, run_request = 1'b0, drive_running = 1'b0, rd_kick = 1'b0;
  logic        hs_code_valid = 1'b0, rst_by_watchdog = 1'b1, rst_by_software = 1'b1;
  logic        regen_model = 1'b1, line_zero_cross = 1'b0, fail = 1'b0, slow = 1'b0;
  logic [2:0]  phase_absent = 3'h0;
  logic [7:0]  prm_addr = 8'h00, nvm_wr_addr, last_wr;
  logic [15:0] prm_wdata = 16'h0000, hs_code = 16'h0000, ctl_board_id_raw = 16'h12ab;
  logic [15:0] ct_board_id = 16'h0033, opt_board_id_raw = 16'h0044;
  logic [15:0] prm_rdata, nvm_wr_data, rdv;
  logic        prm_ack, run_permit, nvm_wr_req, nvm_busy, nvm_op_done, nvm_op_read;
  logic        nvm_op_err, nvm_alarm, over_temperature, reverse_bridge_en, fan_on;
  int          n_mismatch = 0, total_checks = 0, nwr = 0, i;

  dsso_system_status i_dsso_system_status (.*);
  dsso_nvm_model i_dsso_nvm_model (.*);

  always #5 clk = ~clk;

  always @(posedge clk)
    if (nvm_wr_req === 1'b1)
    begin
      nwr <= nwr + 1;
      last_wr <= nvm_wr_addr;
    end

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic acc(input logic w, input logic k, input logic [7:0] a, input logic [15:0] d);
    prm_req <= 1'b1;
    prm_wr <= w;
    prm_from_keypad <= k;
    prm_addr <= a;
    prm_wdata <= d;
    @(posedge clk);
    prm_req <= 1'b0;
    @(posedge clk);
    chk("ack", 16'h0001, {15'h0, prm_ack});
    rdv = prm_rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, 1'b0, a, 16'h0000);
    chk($sformatf("index %h", a), e, rdv);
  endtask

  // Synced pins need a few edges before they show
  task automatic hsk(input logic [15:0] c);
    hs_code <= c;
    hs_code_valid <= 1'b1;
    @(posedge clk);
    hs_code_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(IDX_RESET_CAUSE, {14'h0, RST_WATCHDOG});
    rd(IDX_MODEL_CAT, VAL_ON);
    rd(IDX_LINE_SEL, {14'h0, LSEL_AUTO});
    rd(IDX_LINE_STATUS, 16'h0000);
    rd(IDX_CTL_ID, 16'h00ab);
    rd(IDX_CT_ID, 16'h0033);
    rd(IDX_CTL_ID_RAW, 16'h12ab);
    rd(IDX_OPT_ID_RAW, 16'h0044);
    rd(IDX_OPT_ID, 16'h0044);
    rd(8'h40, 16'h0000);
    phase_absent <= 3'h2;
    hsk(16'h0100);
    rd(IDX_PHASE_MISSING, VAL_ON);
    phase_absent <= 3'h0;
    keypad_editing <= 1'b1;
    run_request <= 1'b1;
    repeat (4) @(posedge clk);
    rd(IDX_PHASE_MISSING, VAL_OFF);
    chk("permit", 16'h0000, {15'h0, run_permit});
    rd(IDX_EDIT_ACTIVE, VAL_ON);
    keypad_editing <= 1'b0;
    repeat (4) @(posedge clk);
    chk("permit", 16'h0001, {15'h0, run_permit});
    chk("fan", 16'h0000, {15'h0, fan_on});
    acc(1'b1, 1'b1, IDX_FAN_MODE, VAL_ON);
    chk("fan", 16'h0001, {15'h0, fan_on});
    repeat (20) @(posedge clk);
    chk("store", 16'h0016, {8'h0, last_wr});
    chk("wdata", VAL_ON, nvm_wr_data);
    i = nwr;
    acc(1'b1, 1'b0, IDX_FAN_MODE, VAL_OFF);
    repeat (20) @(posedge clk);
    chk("stores", i[15:0], nwr[15:0]);
    hsk(16'h0400);
    chk("ot", 16'h0001, {15'h0, over_temperature});
    rd(IDX_HS_CODE, 16'h0400);
    rd(IDX_HS_CELSIUS, 16'h0064);
    rd(IDX_FAN_STATUS, VAL_ON);
    acc(1'b1, 1'b0, IDX_HS_OT_LEVEL, 16'h0000);
    rd(IDX_HS_OT_LEVEL, 16'h005a);
    hsk(16'h0100);
    chk("ot", 16'h0000, {15'h0, over_temperature});
    rd(IDX_FAN_STATUS, VAL_OFF);
    acc(1'b1, 1'b0, IDX_LINE_SEL, 16'h0001);
    rd(IDX_LINE_STATUS, HZ_50);
    acc(1'b1, 1'b0, IDX_LINE_SEL, 16'h0002);
    acc(1'b1, 1'b0, IDX_LINE_SEL, 16'h0003);
    rd(IDX_LINE_STATUS, HZ_60);
    drive_running <= 1'b1;
    acc(1'b1, 1'b0, IDX_LINE_SEL, 16'h0000);
    acc(1'b1, 1'b0, IDX_REGEN_EN, VAL_OFF);
    rd(IDX_LINE_SEL, 16'h0002);
    rd(IDX_REGEN_EN, VAL_ON);
    chk("bridge", 16'h0001, {15'h0, reverse_bridge_en});
    drive_running <= 1'b0;
    acc(1'b1, 1'b0, IDX_REGEN_EN, VAL_OFF);
    chk("bridge", 16'h0000, {15'h0, reverse_bridge_en});
    fail <= 1'b1;
    acc(1'b1, 1'b1, IDX_FAN_MODE, VAL_OFF);
    repeat (20) @(posedge clk);
    chk("alarm", 16'h0001, {15'h0, nvm_alarm});
    rd(IDX_NVM_FAULT, {14'h0, NVM_WRITE_FAULT});
    rd(IDX_NVM_ALARM, 16'h0016);
    // A failed read reports a read fault but is no store, so no new alarm
    rd_kick <= 1'b1;
    @(posedge clk);
    rd_kick <= 1'b0;
    repeat (3) @(posedge clk);
    rd(IDX_NVM_FAULT, {14'h0, NVM_READ_FAULT});
    rd(IDX_NVM_ALARM, 16'h0016);
    fail <= 1'b0;
    slow <= 1'b1;
    i = nwr;
    acc(1'b1, 1'b0, IDX_SAVE_ALL, VAL_ON);
    rd(IDX_SAVE_ALL, VAL_ON);
    for (int j = 0; j < 60 && rdv !== 16'h0000; j++)
      acc(1'b0, 1'b0, IDX_SAVE_ALL, 16'h0000);
    rd(IDX_SAVE_ALL, VAL_OFF);
    chk("stores", i[15:0] + 16'h0004, nwr[15:0]);
    chk("alarm", 16'h0000, {15'h0, nvm_alarm});
    rd(IDX_NVM_FAULT, {14'h0, NVM_NO_FAULT});
    // Mid-run resets on a non-regenerative strap: software, then external cause
    regen_model <= 1'b0;
    rst_by_watchdog <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      rst_by_software <= (k == 0);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(IDX_RESET_CAUSE, (k == 0) ? 16'(RST_SOFTWARE) : 16'(RST_EXTERNAL));
    end
    rd(IDX_MODEL_CAT, VAL_OFF);
    rd(IDX_REGEN_EN, VAL_ON);
    chk("bridge", 16'h0000, {15'h0, reverse_bridge_en});
    chk("fan", 16'h0000, {15'h0, fan_on});
    rd(IDX_NVM_ALARM, 16'h0000);
    stop_test();
  end

  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule // dsso_system_status_tb

`default_nettype wire
